// *** rtl/rrc_alu.sv ***
// Purpose: Rotate an 8-bit operand one place right through the carry flag.
// Assumes: Operand and carry come from registered state in the core.
// Notes:   Purely combinational; negative and zero follow the rotated result, carry takes operand bit 0.
`timescale 1ns/100ps
module rrc_alu (
    rrc_alu_if.alu port_a      // Operand in, result and flags out.
);
    // Old bit 0 leaves to carry, old carry enters bit 7.
    assign port_a.result    = {port_a.carry_in, port_a.operand[7:1]};
    assign port_a.carry_out = port_a.operand[0];

    // Negative and zero are taken from the result, not the operand.
    assign port_a.negative  = port_a.result[7];
    assign port_a.zero      = (port_a.result == 8'h00);
endmodule

// *** rtl/rrc_alu_if.sv ***
// Purpose: Carrier between the execution core and its rotate datapath.
// Assumes: Purely combinational signals on the core clock.
// Notes:   The core drives the operand and carry in, the datapath returns result and flags.
`timescale 1ns/100ps
interface rrc_alu_if;
    logic [7:0] operand;
    logic       carry_in;
    logic [7:0] result;
    logic       carry_out;
    logic       negative;
    logic       zero;

    modport alu  (input operand, carry_in, output result, carry_out, negative, zero);
    modport core (output operand, carry_in, input result, carry_out, negative, zero);
endinterface

// *** rtl/rrc_core.sv ***
// Purpose: Execution of the rotate-right-through-carry operation behind an Avalon-MM slave.
// Assumes: One clock, synchronous active-low reset, one bus request outstanding at a time.
// Notes:   Writing an opcode to the instruction register executes it in that same cycle.
`timescale 1ns/100ps

// Function
// - Rotate file value right one bit; bit 0 to carry, carry to bit 7.
// - Destination bit zero: result to working register, file byte untouched.
// - Destination bit one: result written back into the source file byte.
// - Access bit zero: address resolves inside the access bank, ignoring bank select.
// - Access bit one: bank select register supplies the upper address bits.
// - Extended set, access zero, address up to 95: indexed literal offset.
module rrc_core
    import rrc_pkg::*;
(
    input  wire logic        clk_i,          // Core clock, 25 MHz.
    input  wire logic        rst_n_i,        // Synchronous reset, active low.
    input  wire logic [4:0]  address_i,      // Byte address of the register.
    input  wire logic        read_i,         // Read request.
    input  wire logic        write_i,        // Write request.
    input  wire logic [3:0]  byteenable_i,   // Byte lanes of a write.
    input  wire logic [31:0] writedata_i,    // Write data.
    output logic [31:0]      readdata_o,     // Read data, valid with waitrequest low.
    output logic             waitrequest_o   // High until the request is taken.
);

    // Bus handshake state and register file.
    logic        wait_r;
    logic        wait_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        ext_en_r;
    logic        rej_r;
    logic [15:0] instr_r;
    logic [7:0]  work_r;
    logic        c_r;
    logic        z_r;
    logic        n_r;
    logic [3:0]  bank_r;
    logic [11:0] litbase_r;
    logic [11:0] faddr_r;
    logic [7:0]  file_mem [FILE_DEPTH];

    // The request is held for one cycle with waitrequest high; the edge after waitrequest drops takes it.
    wire         req      = read_i | write_i;
    wire         take     = req & ~wait_r;
    wire         wr_do    = take & write_i;
    assign wait_nxt       = ~(req & wait_r);
    assign waitrequest_o  = wait_r;
    assign readdata_o     = rdata_r;

    // Byte-lane merge: lanes not enabled keep the present register value.
    wire  [31:0] be_mask  = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                             {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
    wire  [31:0] wd       = writedata_i & be_mask;

    // Register selects.
    wire         sel_ctrl   = (address_i == REG_CTRL);
    wire         sel_instr  = (address_i == REG_INSTR);
    wire         sel_work   = (address_i == REG_WORK);
    wire         sel_status = (address_i == REG_STATUS);
    wire         sel_bank   = (address_i == REG_BANK);
    wire         sel_lit    = (address_i == REG_LITBASE);
    wire         sel_faddr  = (address_i == REG_FADDR);
    wire         sel_fdata  = (address_i == REG_FDATA);

    // Opcode fields of the word being written.
    wire  [15:0] op_w     = writedata_i[15:0];
    wire         op_ok    = (op_w[OP_PRE_MSB:OP_PRE_LSB] == OP_PREFIX);
    wire         op_d     = op_w[OP_D_BIT];
    wire         op_a     = op_w[OP_A_BIT];
    wire  [7:0]  op_f     = op_w[OP_F_MSB:0];
    wire         op_wr    = wr_do & sel_instr & (&byteenable_i[1:0]);
    wire         exec     = op_wr & op_ok;
    wire         reject   = op_wr & ~op_ok;

    // Address resolution for the three addressing modes.
    wire         lit_mode = ext_en_r & ~op_a & (op_f <= LIT_MAX_F);
    wire  [11:0] lit_addr = litbase_r + {4'h0, op_f};
    wire  [3:0]  acc_bank = (op_f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK;
    wire  [11:0] acc_addr = {acc_bank, op_f};
    wire  [11:0] bank_addr = {bank_r, op_f};
    wire  [11:0] res_addr = lit_mode ? lit_addr : (op_a ? bank_addr : acc_addr);
    // The flop file is small, so only the low address bits index it and banks alias.
    wire  [FILE_IW-1:0] x_idx = res_addr[FILE_IW-1:0];
    wire  [FILE_IW-1:0] s_idx = faddr_r[FILE_IW-1:0];
    wire  [7:0]  src_val  = file_mem[x_idx];
    wire  [6:0]  src_hi   = src_val[7:1];
    wire         src_b0   = src_val[0];

    // Rotate datapath.
    rrc_alu_if alu_if ();
    assign alu_if.operand  = src_val;
    assign alu_if.carry_in = c_r;

    rrc_alu u_alu (
        .port_a (alu_if.alu)
    );

    // Read mux; unmapped offsets read zero.
    wire  [31:0] rd_ctrl   = {30'h0, rej_r, ext_en_r};
    wire  [31:0] rd_status = {29'h0, n_r, z_r, c_r};
    assign rdata_nxt =
        sel_ctrl   ? rd_ctrl :
        sel_instr  ? {16'h0, instr_r} :
        sel_work   ? {24'h0, work_r} :
        sel_status ? rd_status :
        sel_bank   ? {28'h0, bank_r} :
        sel_lit    ? {20'h0, litbase_r} :
        sel_faddr  ? {20'h0, faddr_r} :
        sel_fdata  ? {24'h0, file_mem[s_idx]} : 32'h0;

    // Write-data merges per register.
    wire  [7:0]  work_wv = (work_r & ~be_mask[7:0]) | wd[7:0];
    wire  [7:0]  fd_wv   = (file_mem[s_idx] & ~be_mask[7:0]) | wd[7:0];
    wire  [11:0] lit_wv  = (litbase_r & ~be_mask[11:0]) | wd[11:0];
    wire  [11:0] fa_wv   = (faddr_r & ~be_mask[11:0]) | wd[11:0];
    wire  [3:0]  bank_wv = (bank_r & ~be_mask[3:0]) | wd[3:0];

    // Bus handshake and read data.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            wait_r  <= wait_nxt;
            if (read_i & wait_r) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Control, bank and base registers written by software.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ext_en_r  <= 1'b0;
            bank_r    <= BANK_RST;
            litbase_r <= ADDR12_RST;
            faddr_r   <= ADDR12_RST;
        end else if (wr_do) begin
            if (sel_ctrl & byteenable_i[0]) begin
                ext_en_r <= writedata_i[CTRL_EXT_BIT];
            end
            if (sel_bank) begin
                bank_r <= bank_wv;
            end
            if (sel_lit) begin
                litbase_r <= lit_wv;
            end
            if (sel_faddr) begin
                faddr_r <= fa_wv;
            end
        end
    end

    // Instruction register and the reject flag of the last opcode written.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            instr_r <= INSTR_RST;
            rej_r   <= 1'b0;
        end else if (op_wr) begin
            instr_r <= op_w;
            rej_r   <= reject;
        end
    end

    // Working register: result lands here only when the destination bit is zero.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            work_r <= WORK_RST;
        end else if (exec & ~op_d) begin
            work_r <= alu_if.result;
        end else if (wr_do & sel_work) begin
            work_r <= work_wv;
        end
    end

    // Status flags: the operation updates all three in its single cycle.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            c_r <= 1'b0;
            z_r <= 1'b0;
            n_r <= 1'b0;
        end else if (exec) begin
            c_r <= alu_if.carry_out;
            z_r <= alu_if.zero;
            n_r <= alu_if.negative;
        end else if (wr_do & sel_status & byteenable_i[0]) begin
            c_r <= writedata_i[ST_C_BIT];
            z_r <= writedata_i[ST_Z_BIT];
            n_r <= writedata_i[ST_N_BIT];
        end
    end

    // File storage: write-back from the operation, else a software byte write.
    // It carries no reset, like a real register file; software initialises it.
    always_ff @(posedge clk_i) begin
        if (exec & op_d) begin
            file_mem[x_idx] <= alu_if.result;
        end else if (wr_do & sel_fdata) begin
            file_mem[s_idx] <= fd_wv;
        end
    end

    // ---- Checks ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_exec_w;
        exec && !op_d;
    endsequence

    sequence s_exec_f;
        exec && op_d;
    endsequence

    chk_rot_to_work: assert property (
        s_exec_w |=> (work_r == {$past(c_r), $past(src_hi)}) && (c_r == $past(src_b0)))
        else $error("Rotated value or carry wrong in working register.");

    chk_work_keeps_file: assert property (
        s_exec_w |=> (file_mem[$past(x_idx)] == $past(src_val)))
        else $error("File byte changed when the destination was the working register.");

    chk_file_writeback: assert property (
        s_exec_f |=> (file_mem[$past(x_idx)] == {$past(c_r), $past(src_hi)})
                     && $stable(work_r))
        else $error("File write-back wrong or working register disturbed.");

    chk_access_bank: assert property (
        exec && !op_a && !lit_mode |->
            res_addr == ((op_f < ACC_SPLIT) ? {ACC_LO_BANK, op_f} : {ACC_HI_BANK, op_f}))
        else $error("Access-bank address resolved wrongly.");

    chk_bank_select: assert property (
        exec && op_a |-> res_addr[11:8] == bank_r && res_addr[7:0] == op_f)
        else $error("Bank select not used for the address.");

    chk_literal_mode: assert property (
        exec && ext_en_r && !op_a |-> lit_mode == (op_f <= LIT_MAX_F)
            && (!lit_mode || res_addr == litbase_r + {4'h0, op_f}))
        else $error("Indexed literal offset applied wrongly.");

    chk_flags_update: assert property (
        exec |=> (z_r == ({$past(c_r), $past(src_hi)} == 8'h00)) && (n_r == $past(c_r))
                 && (rej_r == 1'b0))
        else $error("Zero, negative or reject flag wrong after the operation.");

    chk_bad_opcode: assert property (
        reject |=> rej_r && $stable(work_r) && $stable(c_r))
        else $error("Unrecognised opcode altered state.");

    chk_bus_answer: assert property (
        req && wait_r |=> !wait_r ##1 wait_r)
        else $error("Waitrequest did not drop for exactly one cycle.");

    // Read data is captured when a read is first seen and must then stand, so a
    // master that samples late still gets the word its own request fetched.
    chk_read_stands: assert property (
        !(read_i && wait_r) |=> $stable(rdata_r))
        else $error("Read data changed without a new read request.");

    // With no request pending the slave keeps waitrequest high; a strobe that rises
    // later must still see its one wait cycle before anything is written.
    chk_idle_waits: assert property (
        !req |=> wait_r)
        else $error("Waitrequest low without a pending request.");

    // A short opcode write is dropped whole: executing it would pair a fresh file address
    // with a stale prefix left in the upper lane.
    sequence s_short_op;
        wr_do && sel_instr && !(&byteenable_i[1:0]);
    endsequence

    chk_short_opcode: assert property (
        s_short_op |=> $stable(instr_r) && $stable(work_r)
                       && $stable(rej_r) && $stable(c_r))
        else $error("Opcode written on too few byte lanes was acted on.");

    // Every accepted opcode word is kept for read-back, executed or not.
    chk_instr_latched: assert property (
        op_wr |=> instr_r == $past(op_w))
        else $error("Instruction register does not hold the opcode written.");

    // The literal offset is reserved for the extended set with the access bit clear;
    // any other combination must fall back to the bank or access-bank path.
    chk_literal_off: assert property (
        exec && !ext_en_r |-> !lit_mode)
        else $error("Literal offset used with the extended set disabled.");

    // The bank select wins over the literal offset whenever the access bit is one.
    chk_bank_over_lit: assert property (
        exec && op_a |-> !lit_mode && res_addr[11:8] == bank_r)
        else $error("Bank select overridden while the access bit was one.");

    // The access bank only ever lands in the bottom or the top bank, offset unchanged.
    chk_access_halves: assert property (
        exec && !op_a && !lit_mode |-> res_addr[7:0] == op_f
            && (res_addr[11:8] == ACC_LO_BANK || res_addr[11:8] == ACC_HI_BANK))
        else $error("Access-bank address left the bottom and top banks.");

endmodule

// *** rtl/rrc_pkg.sv ***
// Purpose: Shared constants for the rotate-right-through-carry execution block.
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one aligned word per register.
// Notes:   Opcode fields, register offsets, status bit positions and reset values.
package rrc_pkg;

    // Opcode layout: fixed prefix, destination bit, access bit, 8-bit file address.
    localparam int          OP_PRE_MSB    = 15;
    localparam int          OP_PRE_LSB    = 10;
    localparam logic [5:0]  OP_PREFIX     = 6'h0c;
    localparam int          OP_D_BIT      = 9;
    localparam int          OP_A_BIT      = 8;
    localparam int          OP_F_MSB      = 7;

    // Addressing constants.
    localparam logic [7:0]  LIT_MAX_F     = 8'h5f;   // Highest offset of literal mode.
    localparam logic [7:0]  ACC_SPLIT     = 8'h60;   // First access-bank byte in the top bank.
    localparam logic [3:0]  ACC_LO_BANK   = 4'h0;
    localparam logic [3:0]  ACC_HI_BANK   = 4'hf;
    localparam int          FILE_DEPTH    = 64;
    localparam int          FILE_IW       = 6;

    // Register byte offsets.
    localparam logic [4:0]  REG_CTRL      = 5'h00;
    localparam logic [4:0]  REG_INSTR     = 5'h04;
    localparam logic [4:0]  REG_WORK      = 5'h08;
    localparam logic [4:0]  REG_STATUS    = 5'h0c;
    localparam logic [4:0]  REG_BANK      = 5'h10;
    localparam logic [4:0]  REG_LITBASE   = 5'h14;
    localparam logic [4:0]  REG_FADDR     = 5'h18;
    localparam logic [4:0]  REG_FDATA     = 5'h1c;

    // Field positions.
    localparam int          CTRL_EXT_BIT  = 0;
    localparam int          CTRL_REJ_BIT  = 1;
    localparam int          ST_C_BIT      = 0;
    localparam int          ST_Z_BIT      = 1;
    localparam int          ST_N_BIT      = 2;

    // Reset values.
    localparam logic [7:0]  WORK_RST      = 8'h00;
    localparam logic [3:0]  BANK_RST      = 4'h0;
    localparam logic [11:0] ADDR12_RST    = 12'h000;
    localparam logic [15:0] INSTR_RST     = 16'h0000;

endpackage

// *** verif/rotate_right_through_carry_test.sv ***
// Purpose: Self-checking bench for the rotate-right-through-carry core over its register bus.
// Assumes: One Avalon-MM request at a time; the core answers after one wait cycle or more.
// Notes:   File storage has no reset, so every byte is written before it is used.
`timescale 1ns/100ps
module rotate_right_through_carry_test
    import rrc_pkg::*;
;
    logic        clk_i        = 1'b0;
    logic        rst_n_i      = 1'b0;
    logic [4:0]  address_i    = 5'h00;
    logic        read_i       = 1'b0;
    logic        write_i      = 1'b0;
    logic [3:0]  byteenable_i = 4'h0;
    logic [31:0] writedata_i  = 32'h0;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    int          n_mismatch   = 0;
    int          checked      = 0;

    rrc_core rrc_core_inst (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .address_i     (address_i),
        .read_i        (read_i),
        .write_i       (write_i),
        .byteenable_i  (byteenable_i),
        .writedata_i   (writedata_i),
        .readdata_o    (readdata_o),
        .waitrequest_o (waitrequest_o)
    );

    // Free-running 25 MHz clock.
    always #20 clk_i = ~clk_i;

    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("Counts: checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Case inequality, so an unknown never passes for a match.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle. Values read right after the edge are those the edge sampled,
    // because the core updates its outputs by non-blocking assignment.
    task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] data,
                       input logic [3:0] be, output logic [31:0] rd);
        int   i;
        logic done;
        @(posedge clk_i);
        address_i    <= addr;
        writedata_i  <= data;
        byteenable_i <= be;
        write_i      <= wr;
        read_i       <= ~wr;
        done = 1'b0;
        rd   = 32'h0;
        for (i = 0; i < 20 && !done; i++) begin
            @(posedge clk_i);
            if (waitrequest_o === 1'b0) begin
                done = 1'b1;
                rd   = readdata_o;
            end
        end
        write_i <= 1'b0;
        read_i  <= 1'b0;
        if (!done) begin
            n_mismatch++;
            $display("Error at %0t: waitrequest never went low", $time);
            results();
        end
    endtask

    task automatic wr(input logic [4:0] addr, input logic [31:0] data,
                      input logic [3:0] be = 4'hf);
        logic [31:0] d;
        bus(1'b1, addr, data, be, d);
    endtask

    task automatic rd_chk(input logic [4:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, addr, 32'h0, 4'h0, d);
        check(d, exp);
    endtask

    // File bytes are reached through the address and data window registers.
    task automatic fset(input logic [5:0] idx, input logic [7:0] v);
        wr(REG_FADDR, {26'h0, idx});
        wr(REG_FDATA, {24'h0, v});
    endtask

    task automatic fchk(input logic [5:0] idx, input logic [7:0] exp);
        wr(REG_FADDR, {26'h0, idx});
        rd_chk(REG_FDATA, {24'h0, exp});
    endtask

    task automatic exec(input logic d, input logic a, input logic [7:0] f);
        wr(REG_INSTR, {16'h0, OP_PREFIX, d, a, f}, 4'h3);
    endtask

    // Runs one rotate on byte idx and compares destination, source and flags.
    task automatic op(input logic d, input logic a, input logic [7:0] f,
                      input logic [5:0] idx, input logic [7:0] v, input logic c);
        logic [7:0] res;
        logic [2:0] st;
        res = {c, v[7:1]};
        st  = {res[7], res == 8'h00, v[0]};
        fset(idx, v);
        wr(REG_WORK, 32'h5a);
        wr(REG_STATUS, {31'h0, c});
        exec(d, a, f);
        rd_chk(REG_STATUS, {29'h0, st});
        rd_chk(REG_WORK, d ? 32'h5a : {24'h0, res});
        fchk(idx, d ? res : v);
    endtask

    // Main sequence: reset, register defaults, then the addressing and flag cases.
    initial begin
        int k;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (k = 0; k < 7; k++) begin
            rd_chk(5'(k * 4), 32'h0);
        end
        op(1'b0, 1'b0, 8'h10, 6'h10, 8'he6, 1'b0);
        op(1'b1, 1'b0, 8'h10, 6'h10, 8'h01, 1'b1);
        op(1'b1, 1'b0, 8'h22, 6'h22, 8'h01, 1'b0);
        op(1'b0, 1'b0, 8'h9a, 6'h1a, 8'hff, 1'b1);
        wr(REG_BANK, 32'h3);
        op(1'b1, 1'b1, 8'h25, 6'h25, 8'h54, 1'b0);
        rd_chk(REG_BANK, 32'h3);
        // Extended set: offset from the index base, and its upper boundary.
        wr(REG_CTRL, 32'h1);
        wr(REG_LITBASE, 32'h005);
        fset(6'h1f, 8'h33);
        op(1'b1, 1'b0, 8'h5f, 6'h24, 8'haa, 1'b1);
        fchk(6'h1f, 8'h33);
        fset(6'h25, 8'h44);
        op(1'b1, 1'b0, 8'h60, 6'h20, 8'h02, 1'b0);
        fchk(6'h25, 8'h44);
        op(1'b1, 1'b1, 8'h10, 6'h10, 8'h80, 1'b1);
        // A wrong prefix must only set the reject flag and load the instruction register; a narrow write must leave the state alone.
        wr(REG_WORK, 32'h5a);
        wr(REG_INSTR, {16'h0, 6'h0d, 2'b00, 8'h10}, 4'h3);
        rd_chk(REG_CTRL, 32'h3);
        rd_chk(REG_WORK, 32'h5a);
        wr(REG_INSTR, {16'h0, OP_PREFIX, 2'b00, 8'h10}, 4'h1);
        rd_chk(REG_WORK, 32'h5a);
        exec(1'b0, 1'b1, 8'h10);
        rd_chk(REG_CTRL, 32'h1);
        rd_chk(REG_INSTR, {16'h0, OP_PREFIX, 2'b01, 8'h10});
        results();
    end
endmodule
